// >>> verilog/lprsa_defs.vh
`ifndef LPRSA_DEFS_VH
`define LPRSA_DEFS_VH

// Register byte offsets
`define LPRSA_REG_CTRL      8'h00
`define LPRSA_REG_STAT      8'h04
`define LPRSA_REG_SRWORD    8'h08

// Control layout; reset is CL 3, burst length 4
`define LPRSA_CTRL_CL3      0
`define LPRSA_CTRL_BL_HI    3
`define LPRSA_CTRL_BL_LO    1
`define LPRSA_CTRL_RESET    4'h5

// Burst length codes
`define LPRSA_BL_2          3'h1
`define LPRSA_BL_4          3'h2
`define LPRSA_BL_8          3'h3
`define LPRSA_BL_16         3'h4

// Status register layout
`define LPRSA_STAT_VIOL     0
`define LPRSA_STAT_VIOL_CLR 32'h0000_0001

// Command codes on {RAS#, CAS#, WE#} with chip select low
`define LPRSA_CMD_LMR       3'h0
`define LPRSA_CMD_REF       3'h1
`define LPRSA_CMD_PRE       3'h2
`define LPRSA_CMD_ACT       3'h3
`define LPRSA_CMD_WR        3'h4
`define LPRSA_CMD_RD        3'h5
`define LPRSA_CMD_BST       3'h6
`define LPRSA_CMD_NOP       3'h7

// Load-mode bank address that requests status
`define LPRSA_BA_STATUS     2'h1

// Counts in 8 ns clocks: 160 ns status waits, 42 ns row active time rounded up
`define LPRSA_SR_SETUP_CYC  8'h14
`define LPRSA_SR_RECOV_CYC  8'h14
`define LPRSA_TRAS_CYC      8'h06

`endif

// >>> verilog/lprsa_sync.v
`timescale 1ns/100ps
`default_nettype none

module lprsa_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clock,
    input  wire         rst_n,
    // Asynchronous inputs and their synchronised copies
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);

    reg [W-1:0] meta_r;

    always @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

`default_nettype wire

// >>> verilog/lprsa_core.v
`timescale 1ns/100ps
`default_nettype none
`include "lprsa_defs.vh"

// Overview of operation
// R1: Controller initialises and idles banks before readout
// R2: Load-mode with bank 01, address zero requests status
// R3: Controller waits status setup, only NOP/DESELECT
// R4: Controller waits status recovery after status read
// R5: Status burst is two beats, second don't-care
// R6: Status word holds maker, revision, multiplier, width, density
// R7: Refresh multiplier follows on-die temperature sensor
// R8: Controller activates row, waits before column command
// R9: Controller precharges before new row, respects interval
// R10: Controller spaces activates to different banks
// R11: Read carries bank, column, auto-precharge choice
// R12: First beat after CAS latency, then every edge
// R13: Strobe driven with data, preamble and postamble low
// R14: Outputs released after burst completes
// R15: Read, BST, same-bank PRE truncate non-AP bursts
// R16: Second read after x cycles continues stream
// R17: New read accepted on any cycle; code drops reads that reach the pins during an auto-precharge burst
// R18: Burst terminate stops data after CAS latency
// R19: Controller ends read burst before any write
// R20: Same-bank precharge after x cycles truncates read
// R21: Controller waits precharge time before bank access
// R22: Auto-precharge starts BL/2 cycles after read, tRAS met
// R23: Each strobe serves one byte lane
// R24: CAS latency two or three clocks
// R25: Controller keeps intervals as cycle counts
// R26: Non-NOP during status waits flagged as violation
module lprsa_core #(
    parameter [7:0] MFR_ID     = 8'h5A,
    parameter [3:0] REV_ID     = 4'h1,
    parameter       WIDTH_TYPE = 1'b1,
    parameter [2:0] DENSITY    = 3'h2
) (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // Register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdData,
    // Memory link: clock and command pins
    input  wire        ckPin,
    input  wire        csPin_n,
    input  wire        rasPin_n,
    input  wire        casPin_n,
    input  wire        wePin_n,
    input  wire [1:0]  baPin,
    input  wire [12:0] addrPin,
    // Memory link: read data and strobes
    output reg  [31:0] dqOut,
    output reg         dqOe,
    output reg  [3:0]  dqsOut,
    output reg  [3:0]  dqsOe,
    // Temperature sensor multiplier code
    input  wire [3:0]  sensorMult
);

    // Pipeline entry fields
    localparam E_V      = 29;
    localparam E_STOP   = 28;
    localparam E_PRE    = 27;
    localparam E_STAT   = 26;
    localparam E_AP     = 25;
    localparam E_BA_HI  = 24;
    localparam E_BA_LO  = 23;
    localparam E_COL_HI = 22;
    localparam E_COL_LO = 13;
    localparam E_ROW_HI = 12;

    // Status readout sequence states
    localparam SR_IDLE  = 2'h0;
    localparam SR_SETUP = 2'h1;
    localparam SR_READY = 2'h2;
    localparam SR_RECOV = 2'h3;

    function [3:0] blPairs;
        input [2:0] code;
        begin
            case (code)
                `LPRSA_BL_2:  blPairs = 4'h1;
                `LPRSA_BL_4:  blPairs = 4'h2;
                `LPRSA_BL_8:  blPairs = 4'h4;
                `LPRSA_BL_16: blPairs = 4'h8;
                default:      blPairs = 4'h2;
            endcase
        end
    endfunction

    // Sequential order, wrapping inside the burst-length block
    function [9:0] nextCol;
        input [9:0] col;
        input [2:0] code;
        reg   [9:0] mask;
        begin
            case (code)
                `LPRSA_BL_2:  mask = 10'h001;
                `LPRSA_BL_4:  mask = 10'h003;
                `LPRSA_BL_8:  mask = 10'h007;
                `LPRSA_BL_16: mask = 10'h00F;
                default:      mask = 10'h003;
            endcase
            nextCol = (col & ~mask) | ((col + 10'h001) & mask);
        end
    endfunction

    // No array behind the pins: each word is a pattern of its own address
    function [31:0] rdWord;
        input [1:0]  ba;
        input [12:0] row;
        input [9:0]  col;
        begin
            rdWord = {ba, row, 7'h00, col};
        end
    endfunction

    // Pin synchronisation; command pins share the delay of the clock pin
    wire [23:0] syncBus;

    lprsa_sync #(
        .W(24)
    ) uSync (
        .clock (clock),
        .rst_n (rst_n),
        .din   ({sensorMult, ckPin, csPin_n, rasPin_n, casPin_n, wePin_n,
                 baPin, addrPin}),
        .dout  (syncBus)
    );

    wire [3:0]  sensS = syncBus[23:20];
    wire        ckS   = syncBus[19];
    wire        csS_n = syncBus[18];
    wire [2:0]  rcwS  = syncBus[17:15];
    wire [1:0]  baS   = syncBus[14:13];
    wire [12:0] addrS = syncBus[12:0];

    reg ckPrev_r;
    wire ckRise = ckS & ~ckPrev_r;
    wire ckFall = ~ckS & ckPrev_r;

    // Control and state registers
    reg  [3:0]  ctrl_r;
    reg         viol_r;
    reg  [1:0]  srState_r;
    reg  [7:0]  srCnt_r;
    reg  [3:0]  bankOpen_r;
    reg  [12:0] openRow_r [0:3];
    reg  [29:0] st1_r;
    reg  [29:0] st2_r;
    reg         bActive_r;
    reg  [3:0]  bPairs_r;
    reg  [9:0]  bCol_r;
    reg  [12:0] bRow_r;
    reg  [1:0]  bBank_r;
    reg         bAp_r;
    reg         bStat_r;
    reg         apPend_r;
    reg  [3:0]  apCnt_r;
    reg  [1:0]  apBank_r;

    wire        cl3    = ctrl_r[`LPRSA_CTRL_CL3];
    wire [2:0]  blCode = ctrl_r[`LPRSA_CTRL_BL_HI:`LPRSA_CTRL_BL_LO];

    // Command decode, only on a link clock rising edge
    wire cmdValid = ckRise & ~csS_n;
    wire isAct    = cmdValid && (rcwS == `LPRSA_CMD_ACT);
    wire isRd     = cmdValid && (rcwS == `LPRSA_CMD_RD);
    wire isBst    = cmdValid && (rcwS == `LPRSA_CMD_BST);
    wire isPre    = cmdValid && (rcwS == `LPRSA_CMD_PRE);
    wire isLmr    = cmdValid && (rcwS == `LPRSA_CMD_LMR);
    wire isOther  = cmdValid && (rcwS != `LPRSA_CMD_NOP);
    wire isStatReq = isLmr && (baS == `LPRSA_BA_STATUS)
                     && (addrS == 13'h0000);                          // [R2]
    wire srRdy    = (srState_r == SR_READY);

    wire [31:0] statusWord = {12'h000, DENSITY, WIDTH_TYPE, sensS,
                              REV_ID, MFR_ID};                        // [R6] [R7]

    // Per-bank row active time
    wire [3:0] rasMet;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gBank
            reg [7:0] rasCnt_r;
            always @(posedge clock) begin
                if (!rst_n) begin
                    rasCnt_r <= 8'h00;
                end else if (isAct && (baS == gi[1:0])) begin
                    rasCnt_r <= 8'h00;
                end else if (rasCnt_r != 8'hFF) begin
                    rasCnt_r <= rasCnt_r + 8'h01;
                end
            end
            assign rasMet[gi] = (rasCnt_r >= `LPRSA_TRAS_CYC);
        end
    endgenerate

    // New pipeline entry: reads, and the truncating commands
    wire [29:0] newEnt = isRd ?
        {1'b1, 1'b0, 1'b0, srRdy, srRdy ? 1'b0 : addrS[10], baS,
         addrS[9:0], openRow_r[baS]} :                                // [R11] [R17]
        (isBst | isPre) ?
        {1'b1, 1'b1, isPre, 1'b0, addrS[10], baS, 10'h000, 13'h0000} :
        30'h0000_0000;

    // Entry reaching the pins at this rising edge: CAS latency minus one
    wire [29:0] emEnt = cl3 ? st2_r : st1_r;                          // [R24] [R12]
    wire        busy  = bActive_r && (bPairs_r != 4'h0);
    wire        emRead = emEnt[E_V] && !emEnt[E_STOP];
    wire        loadNew = ckRise && emRead && !(busy && bAp_r);       // [R15] [R16]
    wire        emStopBank = !emEnt[E_PRE] || emEnt[E_AP]
                             || (emEnt[E_BA_HI:E_BA_LO] == bBank_r);
    wire        stopHit = ckRise && emEnt[E_V] && emEnt[E_STOP] && busy
                          && !bAp_r && emStopBank;                    // [R18] [R20] [R15]
    wire        apFire = apPend_r && (apCnt_r == 4'h0) && rasMet[apBank_r]; // [R22]

    wire [9:0]  loadCol = emEnt[E_COL_HI:E_COL_LO];
    wire [9:0]  fallCol = nextCol(bCol_r, blCode);

    always @(posedge clock) begin
        if (!rst_n) begin
            ckPrev_r <= 1'b0;
            st1_r    <= 30'h0000_0000;
            st2_r    <= 30'h0000_0000;
        end else begin
            ckPrev_r <= ckS;
            if (ckRise) begin
                st1_r <= newEnt;
                st2_r <= st1_r;
            end
        end
    end

    // Burst engine and pin drivers
    always @(posedge clock) begin
        if (!rst_n) begin
            bActive_r <= 1'b0;
            bPairs_r  <= 4'h0;
            bCol_r    <= 10'h000;
            bRow_r    <= 13'h0000;
            bBank_r   <= 2'h0;
            bAp_r     <= 1'b0;
            bStat_r   <= 1'b0;
            dqOut     <= 32'h0000_0000;
            dqOe      <= 1'b0;
            dqsOut    <= 4'h0;
            dqsOe     <= 4'h0;
        end else if (ckRise) begin
            if (loadNew) begin
                bActive_r <= 1'b1;
                bPairs_r  <= emEnt[E_STAT] ? 4'h1 : blPairs(blCode);  // [R5]
                bCol_r    <= loadCol;
                bRow_r    <= emEnt[E_ROW_HI:0];
                bBank_r   <= emEnt[E_BA_HI:E_BA_LO];
                bAp_r     <= emEnt[E_AP];
                bStat_r   <= emEnt[E_STAT];
                dqOut     <= emEnt[E_STAT] ? statusWord :
                             rdWord(emEnt[E_BA_HI:E_BA_LO], emEnt[E_ROW_HI:0], loadCol);
                dqOe      <= 1'b1;
                dqsOut    <= 4'hF;                                    // [R13] [R23]
                dqsOe     <= 4'hF;
            end else if (busy && !stopHit) begin
                dqOut  <= rdWord(bBank_r, bRow_r, bCol_r);            // [R12]
                dqsOut <= 4'hF;
            end else begin
                bActive_r <= 1'b0;
                bPairs_r  <= 4'h0;
                dqOe      <= 1'b0;                                    // [R14]
                dqsOe     <= 4'h0;
                dqsOut    <= 4'h0;
            end
        end else if (ckFall) begin
            if (busy) begin
                dqOut    <= bStat_r ? 32'h0000_0000 :
                            rdWord(bBank_r, bRow_r, fallCol);         // [R5] [R12]
                dqsOut   <= 4'h0;                                     // [R13]
                bPairs_r <= bPairs_r - 4'h1;
                bCol_r   <= nextCol(fallCol, blCode);
            end else if (emRead) begin
                dqsOut <= 4'h0;                                       // [R13]
                dqsOe  <= 4'hF;
            end
        end
    end

    // Bank rows and auto-precharge
    integer bi;
    always @(posedge clock) begin
        if (!rst_n) begin
            bankOpen_r <= 4'h0;
            apPend_r   <= 1'b0;
            apCnt_r    <= 4'h0;
            apBank_r   <= 2'h0;
            for (bi = 0; bi < 4; bi = bi + 1) begin
                openRow_r[bi] <= 13'h0000;
            end
        end else begin
            for (bi = 0; bi < 4; bi = bi + 1) begin
                if (isAct && (baS == bi[1:0])) begin
                    bankOpen_r[bi] <= 1'b1;
                    openRow_r[bi]  <= addrS;
                end else if ((isPre && (addrS[10] || (baS == bi[1:0])))
                             || (apFire && (apBank_r == bi[1:0]))) begin
                    bankOpen_r[bi] <= 1'b0;                           // [R22]
                end
            end
            if (isRd && addrS[10] && !srRdy) begin
                apPend_r <= 1'b1;
                apCnt_r  <= blPairs(blCode);                          // [R22]
                apBank_r <= baS;
            end else if (apFire) begin
                apPend_r <= 1'b0;
            end else if (ckRise && apPend_r && (apCnt_r != 4'h0)) begin
                apCnt_r <= apCnt_r - 4'h1;
            end
        end
    end

    // Status readout sequence and protocol watch
    reg  [1:0] srState_nxt;
    reg  [7:0] srCnt_nxt;
    reg        violSet;

    always @* begin
        srState_nxt = srState_r;
        srCnt_nxt   = srCnt_r;
        violSet     = 1'b0;
        case (srState_r)
            SR_IDLE: begin
                if (isStatReq) begin
                    srState_nxt = SR_SETUP;                           // [R2]
                    srCnt_nxt   = `LPRSA_SR_SETUP_CYC;
                    violSet     = (bankOpen_r != 4'h0);
                end
            end
            SR_SETUP: begin
                violSet = isOther;                                    // [R26]
                if (srCnt_r <= 8'h01) begin
                    srState_nxt = SR_READY;
                    srCnt_nxt   = 8'h00;
                end else begin
                    srCnt_nxt = srCnt_r - 8'h01;
                end
            end
            SR_READY: begin
                if (isRd) begin
                    srState_nxt = SR_RECOV;
                    srCnt_nxt   = `LPRSA_SR_RECOV_CYC;
                end else if (isOther) begin
                    violSet     = 1'b1;                               // [R26]
                    srState_nxt = SR_IDLE;
                end
            end
            SR_RECOV: begin
                violSet = isOther;                                    // [R26]
                if (srCnt_r <= 8'h01) begin
                    srState_nxt = SR_IDLE;
                    srCnt_nxt   = 8'h00;
                end else begin
                    srCnt_nxt = srCnt_r - 8'h01;
                end
            end
            default: begin
                srState_nxt = SR_IDLE;
                srCnt_nxt   = 8'h00;
            end
        endcase
    end

    wire violClr = regWr && (regAddr == `LPRSA_REG_STAT) && regWrData[`LPRSA_STAT_VIOL];

    // Register port; a set in the cycle of a clear keeps the flag
    always @(posedge clock) begin
        if (!rst_n) begin
            srState_r <= SR_IDLE;
            srCnt_r   <= 8'h00;
            viol_r    <= 1'b0;
            ctrl_r    <= `LPRSA_CTRL_RESET;
            regRdData <= 32'h0000_0000;
        end else begin
            srState_r <= srState_nxt;
            srCnt_r   <= srCnt_nxt;
            viol_r    <= (viol_r & ~violClr) | violSet;               // [R26]
            if (regWr && (regAddr == `LPRSA_REG_CTRL)) begin
                ctrl_r <= regWrData[3:0];
            end
            if (regRd) begin
                case (regAddr)
                    `LPRSA_REG_CTRL:   regRdData <= {28'h000_0000, ctrl_r};
                    `LPRSA_REG_STAT:   regRdData <= {24'h00_0000, srState_r,
                                                     bActive_r, bankOpen_r, viol_r};
                    `LPRSA_REG_SRWORD: regRdData <= statusWord;
                    default:           regRdData <= 32'h0000_0000;
                endcase
            end else begin
                regRdData <= 32'h0000_0000;
            end
        end
    end

endmodule

`default_nettype wire

// >>> verif/lprsa_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module lprsa_core_sva #(
    parameter logic [7:0] MFR_ID     = 8'h5A,
    parameter logic [3:0] REV_ID     = 4'h1,
    parameter logic       WIDTH_TYPE = 1'b1,
    parameter logic [2:0] DENSITY    = 3'h2
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Register port
    input wire logic [7:0]  regAddr,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    // Read data and strobes
    input wire logic        dqOe,
    input wire logic [3:0]  dqsOut,
    input wire logic [3:0]  dqsOe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    srword_fields_a: assert property (
        regRd && regAddr == 8'h08 |=> regRdData[31:16] == {12'h000, DENSITY, WIDTH_TYPE}
        && regRdData[11:0] == {REV_ID, MFR_ID}) else $error("bad status word");
    lanes_agree_a: assert property (
        dqsOe == {4{dqsOe[0]}} && dqsOut == {4{dqsOut[0]}}) else $error("lanes differ");
    strobe_needs_oe_a: assert property (
        dqsOut != 4'h0 |-> dqsOe == 4'hF) else $error("strobe undriven");
    data_has_strobe_a: assert property (
        dqOe |-> dqsOe == 4'hF) else $error("data without strobe");
    preamble_low_a: assert property (
        $rose(dqOe) |-> dqsOut == 4'hF && $past(dqsOe) == 4'hF && $past(dqsOut) == 4'h0)
        else $error("no preamble");
    preamble_enter_a: assert property (
        $rose(dqsOe[0]) |-> dqsOut == 4'h0 && !dqOe) else $error("strobe enable not low");
    postamble_release_a: assert property (
        $fell(dqOe) |-> dqsOe == 4'h0 && $past(dqsOut) == 4'h0)
        else $error("bad postamble or release");
    beat_hold_a: assert property (
        dqOe && dqsOut != $past(dqsOut) |=> $stable(dqsOut) [*3])
        else $error("beat too short");
endmodule

bind lprsa_core lprsa_core_sva #(.MFR_ID(MFR_ID), .REV_ID(REV_ID), .WIDTH_TYPE(WIDTH_TYPE),
    .DENSITY(DENSITY)) u_lprsa_core_sva (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regRd(regRd), .regRdData(regRdData), .dqOe(dqOe), .dqsOut(dqsOut), .dqsOe(dqsOe));
`default_nettype wire

// >>> verif/lprsa_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module lprsa_ctrl_model (
    // Link clock and command pins
    output var logic        ckPin,
    output var logic        csPin_n,
    output var logic        rasPin_n,
    output var logic        casPin_n,
    output var logic        wePin_n,
    output var logic [1:0]  baPin,
    output var logic [12:0] addrPin
);
    realtime lastRise;

    initial begin
        ckPin = 1'b0;
        csPin_n = 1'b1;
        {rasPin_n, casPin_n, wePin_n} = 3'h7;
        baPin = 2'h0;
        addrPin = 13'h0000;
    end

    always #40 ckPin = ~ckPin;

    // Driven on the fall so pins settle before the sampling rise; never a write
    task automatic cmd(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a);
        @(negedge ckPin);
        csPin_n <= 1'b0;
        {rasPin_n, casPin_n, wePin_n} <= c;
        baPin <= ba;
        addrPin <= a;
        @(posedge ckPin);
        lastRise = $realtime;
    endtask

    // NOP gaps; callers size them for the waits
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge ckPin);
            {rasPin_n, casPin_n, wePin_n} <= 3'h7;
            addrPin <= ~addrPin;
        end
    endtask
endmodule
`default_nettype wire

// >>> verif/lprsa_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lprsa_defs.vh"
module lprsa_core_tb_top;
    localparam logic [7:0] MFR = 8'hA7; // Arbitrary maker code
    localparam logic [3:0] REV = 4'h3;  // Arbitrary revision
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [3:0]  sensorMult = 4'h9;
    wire logic [31:0] regRdData, dqOut;
    wire logic [3:0]  dqsOut, dqsOe;
    wire logic [12:0] addrPin;
    wire logic [1:0]  baPin;
    wire logic        dqOe, ckPin, csPin_n, rasPin_n, casPin_n, wePin_n;
    int mismatches = 0;
    int compares = 0;
    logic [31:0] beats[$];
    realtime firstBeatT;
    logic [3:0] dqsPrev = 4'h0;

    always #4 clock = ~clock;

    lprsa_core #(.MFR_ID(MFR), .REV_ID(REV), .WIDTH_TYPE(1'b0), .DENSITY(3'h5)) u_lprsa_core (
        .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .ckPin(ckPin),
        .csPin_n(csPin_n), .rasPin_n(rasPin_n), .casPin_n(casPin_n), .wePin_n(wePin_n),
        .baPin(baPin), .addrPin(addrPin), .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut),
        .dqsOe(dqsOe), .sensorMult(sensorMult));
    lprsa_ctrl_model u_lprsa_ctrl_model (.ckPin(ckPin), .csPin_n(csPin_n),
        .rasPin_n(rasPin_n), .casPin_n(casPin_n), .wePin_n(wePin_n), .baPin(baPin),
        .addrPin(addrPin));

    // Each strobe change while driving marks one beat
    always @(posedge clock) begin
        dqsPrev <= dqsOut;
        if (dqOe === 1'b1 && dqsOut !== dqsPrev) begin
            if (beats.size() == 0) firstBeatT = $realtime;
            beats.push_back(dqOut);
        end
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic compareVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        d = regRdData;
    endtask

    task automatic link(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a);
        u_lprsa_ctrl_model.cmd(c, ba, a);
    endtask

    task automatic idle(input int n);
        u_lprsa_ctrl_model.idle(n);
    endtask

    function automatic logic [31:0] srWord(input logic [3:0] m);
        return {12'h000, 3'h5, 1'b0, m, REV, MFR};
    endfunction

    task automatic expectBurst(input int base, input logic [1:0] ba, input logic [12:0] row,
        input logic [9:0] col, input int bl, input int n);
        logic [9:0] c;
        for (int i = 0; i < n; i++) begin
            c = (col & ~10'(bl - 1)) | ((col + 10'(i)) & 10'(bl - 1));
            compareVal("read beat", {ba, row, 7'h00, c}, beats[base + i]);
        end
    endtask

    // Sync lag is a few system clocks
    task automatic expectLatency(input realtime rdT, input int cl);
        realtime d;
        d = firstBeatT - rdT - (cl - 1) * 80.0;
        compareVal("first beat delay", 32'h1, {31'h0, d >= 24.0 && d <= 64.0});
    endtask

    task automatic t_regs();
        logic [31:0] d;
        regRead(`LPRSA_REG_CTRL, d);
        compareVal("ctrl reset", 32'h5, d);
        regRead(8'h0C, d);
        compareVal("unmapped read", 32'h0, d);
        regRead(`LPRSA_REG_SRWORD, d);
        compareVal("status word", srWord(4'h9), d);
        @(posedge clock);
        sensorMult <= 4'h4;
        repeat (4) @(posedge clock);
        regRead(`LPRSA_REG_SRWORD, d);
        compareVal("status word", srWord(4'h4), d);
        $display("test regs done");
    endtask

    task automatic t_read_cl3();
        realtime t;
        logic [31:0] d;
        beats.delete();
        link(`LPRSA_CMD_ACT, 2'h1, 13'h1234);
        idle(1);
        link(`LPRSA_CMD_RD, 2'h1, 13'h0005);
        t = u_lprsa_ctrl_model.lastRise;
        idle(6);
        compareVal("beat count", 32'h4, 32'(beats.size()));
        expectBurst(0, 2'h1, 13'h1234, 10'h005, 4, 4);
        expectLatency(t, 3);
        compareVal("drive released", 32'h0, {30'h0, dqOe, dqsOe[0]});
        regRead(`LPRSA_REG_STAT, d);
        compareVal("open banks", 32'h4, d & 32'hFF);
        link(`LPRSA_CMD_PRE, 2'h1, 13'h0000);
        idle(2);
        $display("test read cl3 done");
    endtask

    task automatic t_cl2_chain();
        realtime t;
        logic [31:0] d;
        regWrite(`LPRSA_REG_CTRL, 32'h6);
        beats.delete();
        link(`LPRSA_CMD_ACT, 2'h2, 13'h0ABC);
        idle(1);
        link(`LPRSA_CMD_RD, 2'h2, 13'h0000);
        t = u_lprsa_ctrl_model.lastRise;
        idle(1);
        link(`LPRSA_CMD_RD, 2'h2, 13'h0010);
        idle(1);
        link(`LPRSA_CMD_PRE, 2'h2, 13'h0000);
        idle(6);
        compareVal("beat count", 32'h8, 32'(beats.size()));
        expectBurst(0, 2'h2, 13'h0ABC, 10'h000, 8, 4);
        expectBurst(4, 2'h2, 13'h0ABC, 10'h010, 8, 4);
        expectLatency(t, 2);
        beats.delete();
        link(`LPRSA_CMD_ACT, 2'h2, 13'h0ABC);
        idle(1);
        link(`LPRSA_CMD_RD, 2'h2, 13'h0008);
        link(`LPRSA_CMD_BST, 2'h0, 13'h0000);
        idle(6);
        compareVal("beat count", 32'h2, 32'(beats.size()));
        expectBurst(0, 2'h2, 13'h0ABC, 10'h008, 8, 2);
        regRead(`LPRSA_REG_STAT, d);
        compareVal("open banks", 32'h8, d & 32'hFF);
        link(`LPRSA_CMD_PRE, 2'h2, 13'h0000);
        idle(2);
        $display("test cl2 chain done");
    endtask

    task automatic t_autopre();
        logic [31:0] d;
        regWrite(`LPRSA_REG_CTRL, 32'h5);
        beats.delete();
        link(`LPRSA_CMD_ACT, 2'h3, 13'h1FFF);
        idle(1);
        link(`LPRSA_CMD_RD, 2'h3, 13'h0402);
        link(`LPRSA_CMD_BST, 2'h0, 13'h0000);
        idle(6);
        compareVal("beat count", 32'h4, 32'(beats.size()));
        expectBurst(0, 2'h3, 13'h1FFF, 10'h002, 4, 4);
        regRead(`LPRSA_REG_STAT, d);
        compareVal("open banks", 32'h0, d & 32'hFF);
        $display("test autoprecharge done");
    endtask

    task automatic t_status();
        realtime t;
        logic [31:0] d;
        regWrite(`LPRSA_REG_CTRL, 32'h9);
        beats.delete();
        link(`LPRSA_CMD_LMR, `LPRSA_BA_STATUS, 13'h0000);
        idle(3);
        link(`LPRSA_CMD_RD, 2'h0, 13'h0000);
        t = u_lprsa_ctrl_model.lastRise;
        idle(4);
        compareVal("beat count", 32'h2, 32'(beats.size()));
        compareVal("status beat", srWord(4'h4), beats[0]);
        expectLatency(t, 3);
        regRead(`LPRSA_REG_STAT, d);
        compareVal("status flags", 32'h0, d & 32'hFF);
        $display("test status done");
    endtask

    task automatic t_violation();
        logic [31:0] d;
        link(`LPRSA_CMD_LMR, `LPRSA_BA_STATUS, 13'h0000);
        link(`LPRSA_CMD_ACT, 2'h0, 13'h0001);
        idle(4);
        regRead(`LPRSA_REG_STAT, d);
        compareVal("violation flag", 32'h1, d & 32'h1);
        link(`LPRSA_CMD_RD, 2'h0, 13'h0000);
        idle(4);
        link(`LPRSA_CMD_PRE, 2'h0, 13'h0400);
        idle(2);
        regWrite(`LPRSA_REG_STAT, `LPRSA_STAT_VIOL_CLR);
        regRead(`LPRSA_REG_STAT, d);
        compareVal("violation clear", 32'h0, d & 32'h1);
        $display("test violation done");
    endtask

    initial begin
        #60000;
        mismatches++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_regs();
        t_read_cl3();
        t_cl2_chain();
        t_autopre();
        t_status();
        t_violation();
        report_and_stop();
    end
endmodule
`default_nettype wire
